// ### design/fifo_level_cmp.sv
// FIFO level comparators for the receive trigger and transmit empty threshold.
// Assumes levels come from the FIFOs as plain occupancy counts.
`timescale 1ns/1ps
`default_nettype none
module fifo_level_cmp #(
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic [LW-1:0] rx_level_i,
  input wire logic [LW-1:0] tx_level_i,
  input wire logic [1:0] rx_trigger_level_i,
  input wire logic [1:0] tx_empty_threshold_i,
  output logic rx_at_trigger_o,
  output logic rx_empty_o,
  output logic tx_at_threshold_o,
  output logic tx_empty_o,
  output logic tx_full_o
);
  function automatic logic [LW-1:0] rx_thresh(input logic [1:0] sel);
    case (sel)
      2'h0: rx_thresh = LW'(1);
      2'h1: rx_thresh = LW'(DEPTH / 4);
      2'h2: rx_thresh = LW'(DEPTH / 2);
      default: rx_thresh = LW'(DEPTH - 2);
    endcase
  endfunction : rx_thresh

  function automatic logic [LW-1:0] tx_thresh(input logic [1:0] sel);
    case (sel)
      2'h0: tx_thresh = LW'(0);
      2'h1: tx_thresh = LW'(2);
      2'h2: tx_thresh = LW'(DEPTH / 4);
      default: tx_thresh = LW'(DEPTH / 2);
    endcase
  endfunction : tx_thresh

  assign rx_at_trigger_o = rx_level_i >= rx_thresh(rx_trigger_level_i);
  assign rx_empty_o = rx_level_i == LW'(0);
  assign tx_at_threshold_o = tx_level_i <= tx_thresh(tx_empty_threshold_i);
  assign tx_empty_o = tx_level_i == LW'(0);
  assign tx_full_o = tx_level_i >= LW'(DEPTH);
endmodule : fifo_level_cmp
`default_nettype wire

// ### design/uart_iifc_map.svh
// Addresses, field positions and reset values of the interrupt ident / FIFO control block.
// Assumes a 32-bit APB byte address; included by name from the design files.
`ifndef UART_IIFC_MAP_SVH
`define UART_IIFC_MAP_SVH
`define IIFC_ADDR 32'h5000_1108
`define IIFC_STAT_ADDR 32'h5000_1180
`define IIFC_MASK_ADDR 32'h5000_1184
`define IIFC_RX_TRIG_LSB 6
`define IIFC_TX_THRESH_LSB 4
`define IIFC_DMA_STYLE_BIT 3
`define IIFC_TXF_BIT 2
`define IIFC_RXF_BIT 1
`define IIFC_FEN_BIT 0
`define IIFC_FIFO_STATUS_LSB 6
`define IIFC_CTRL_RST 6'h00
`define IIFC_STAT_RST 6'h00
`define IIFC_MASK_RST 6'h00
`endif

// ### design/uart_iifc_pkg.sv
// Types shared by the interrupt ident / FIFO control block.
// No assumptions beyond a SystemVerilog package scope.
package uart_iifc_pkg;
  typedef enum logic [3:0] {
    INT_MODEM = 4'h0,
    INT_NONE = 4'h1,
    INT_TX_EMPTY = 4'h2,
    INT_RDA = 4'h4,
    INT_RLS = 4'h6,
    INT_BUSY = 4'h7,
    INT_CTO = 4'hC
  } int_code_e;
  // Gray sequence idle -> setup -> access
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_ACCESS = 2'h3
  } apb_phase_e;
  typedef struct packed {
    logic [1:0] rx_trigger_level;
    logic [1:0] tx_empty_threshold;
    logic dma_signal_style;
    logic fifo_enable;
  } fifo_ctrl_s;
  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic char_timeout;
    logic tx_empty;
    logic modem_status;
    logic busy;
  } int_src_s;
endpackage : uart_iifc_pkg

// ### design/uart_int_ident_fifo_ctrl.sv
// Interrupt identification / FIFO control register of a UART, with APB slave,
// sticky event status and mask, flow control and DMA request generation.
// Assumes FIFO levels and raw interrupt causes come from the UART core, synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "uart_iifc_map.svh"
module uart_int_ident_fifo_ctrl #(
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [LW-1:0] rx_fifo_level_i,
  input wire logic [LW-1:0] tx_fifo_level_i,
  input wire logic rx_data_ready_i,
  input wire logic thr_empty_i,
  input wire logic line_status_err_i,
  input wire logic char_timeout_i,
  input wire logic modem_status_chg_i,
  input wire logic busy_detect_i,
  input wire logic line_status_int_en_i,
  input wire logic rx_data_int_en_i,
  input wire logic tx_empty_int_en_i,
  input wire logic modem_status_int_en_i,
  input wire logic prog_tx_empty_mode_i,
  input wire logic auto_flow_en_i,
  input wire logic rts_req_i,
  output logic fifo_enable_o,
  output logic tx_fifo_flush_o,
  output logic rx_fifo_flush_o,
  output logic rts_n_o,
  output logic dma_tx_req_n_o,
  output logic dma_rx_req_n_o,
  output logic uart_int_o,
  output logic irq_o
);
  uart_iifc_pkg::fifo_ctrl_s ctrl, next_ctrl;
  uart_iifc_pkg::int_src_s src, src_q, next_src_q;
  uart_iifc_pkg::int_code_e code;
  uart_iifc_pkg::apb_phase_e phase, next_phase;
  logic [5:0] status, next_status, mask, next_mask;
  logic [31:0] next_prdata;
  logic next_tx_flush, next_rx_flush, next_rts_n, next_uart_int;
  logic rx_dma_act, next_rx_dma_act, tx_dma_act, next_tx_dma_act;
  logic next_dma_tx_req_n, next_dma_rx_req_n;
  logic rx_at_trigger, rx_empty, tx_at_threshold, tx_empty, tx_full;
  logic access, rd_setup, wr_iifc, wr_stat, wr_mask, hit;
  logic rda, tx_holding_empty, rx_any, tx_idle;

  fifo_level_cmp #(.DEPTH(DEPTH), .LW(LW)) u_cmp (
    .rx_level_i(rx_fifo_level_i),
    .tx_level_i(tx_fifo_level_i),
    .rx_trigger_level_i(ctrl.rx_trigger_level),
    .tx_empty_threshold_i(ctrl.tx_empty_threshold),
    .rx_at_trigger_o(rx_at_trigger),
    .rx_empty_o(rx_empty),
    .tx_at_threshold_o(tx_at_threshold),
    .tx_empty_o(tx_empty),
    .tx_full_o(tx_full)
  );

  function automatic uart_iifc_pkg::int_code_e pick(input uart_iifc_pkg::int_src_s s);
    if (s.line_status) begin
      pick = uart_iifc_pkg::INT_RLS;
    end else if (s.rx_data) begin
      pick = uart_iifc_pkg::INT_RDA;
    end else if (s.char_timeout) begin
      pick = uart_iifc_pkg::INT_CTO;
    end else if (s.tx_empty) begin
      pick = uart_iifc_pkg::INT_TX_EMPTY;
    end else if (s.modem_status) begin
      pick = uart_iifc_pkg::INT_MODEM;
    end else if (s.busy) begin
      pick = uart_iifc_pkg::INT_BUSY;
    end else begin
      pick = uart_iifc_pkg::INT_NONE;
    end
  endfunction : pick

  function automatic logic is_addr(input logic [31:0] a, input logic [31:0] ref_a);
    is_addr = a == ref_a;
  endfunction : is_addr

  // APB: zero wait states; a write lands on the access edge only
  assign hit = is_addr(paddr_i, `IIFC_ADDR) || is_addr(paddr_i, `IIFC_STAT_ADDR)
    || is_addr(paddr_i, `IIFC_MASK_ADDR);
  assign access = psel_i && penable_i && (phase == uart_iifc_pkg::PH_SETUP);
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign wr_iifc = access && pwrite_i && is_addr(paddr_i, `IIFC_ADDR);
  assign wr_stat = access && pwrite_i && is_addr(paddr_i, `IIFC_STAT_ADDR);
  assign wr_mask = access && pwrite_i && is_addr(paddr_i, `IIFC_MASK_ADDR);
  assign pready_o = 1'b1;
  assign pslverr_o = access && !hit;

  always_comb begin
    next_phase = uart_iifc_pkg::PH_IDLE;
    case (phase)
      uart_iifc_pkg::PH_IDLE: begin
        if (psel_i && !penable_i) begin
          next_phase = uart_iifc_pkg::PH_SETUP;
        end
      end
      uart_iifc_pkg::PH_SETUP: begin
        next_phase = penable_i ? uart_iifc_pkg::PH_ACCESS : uart_iifc_pkg::PH_SETUP;
      end
      uart_iifc_pkg::PH_ACCESS: begin
        if (psel_i && !penable_i) begin
          next_phase = uart_iifc_pkg::PH_SETUP;
        end
      end
      default: next_phase = uart_iifc_pkg::PH_IDLE;
    endcase
  end

  // Control fields; flush bits are never stored, and on read their positions carry code bits 2:1
  always_comb begin
    next_ctrl = ctrl;
    next_tx_flush = 1'b0;
    next_rx_flush = 1'b0;
    if (wr_iifc) begin
      next_ctrl.rx_trigger_level = pwdata_i[`IIFC_RX_TRIG_LSB +: 2];
      next_ctrl.tx_empty_threshold = pwdata_i[`IIFC_TX_THRESH_LSB +: 2];
      next_ctrl.dma_signal_style = pwdata_i[`IIFC_DMA_STYLE_BIT];
      next_ctrl.fifo_enable = pwdata_i[`IIFC_FEN_BIT];
      next_tx_flush = pwdata_i[`IIFC_TXF_BIT];
      next_rx_flush = pwdata_i[`IIFC_RXF_BIT];
    end
  end

  // Interrupt causes; outside FIFO mode the single-character flags stand in
  always_comb begin
    rda = ctrl.fifo_enable ? rx_at_trigger : rx_data_ready_i;
    tx_holding_empty = ctrl.fifo_enable ? tx_empty : thr_empty_i;
    if (ctrl.fifo_enable && prog_tx_empty_mode_i) begin
      tx_holding_empty = tx_at_threshold;
    end
    src.line_status = line_status_err_i && line_status_int_en_i;
    src.rx_data = rda && rx_data_int_en_i;
    src.char_timeout = char_timeout_i && ctrl.fifo_enable && rx_data_int_en_i;
    src.tx_empty = tx_holding_empty && tx_empty_int_en_i;
    src.modem_status = modem_status_chg_i && modem_status_int_en_i;
    src.busy = busy_detect_i;
    code = pick(src);
  end

  // Sticky events: a new rising cause beats a write-one clear in the same cycle
  always_comb begin
    next_src_q = src;
    next_mask = wr_mask ? pwdata_i[5:0] : mask;
    next_status = status;
    if (wr_stat) begin
      next_status = status & ~pwdata_i[5:0];
    end
    next_status = next_status | (src & ~src_q);
    next_uart_int = code != uart_iifc_pkg::INT_NONE;
  end
  assign irq_o = |(status & mask);

  // Read data is captured in the setup cycle so it stands through access
  always_comb begin
    next_prdata = prdata_o;
    if (rd_setup) begin
      next_prdata = 32'h0000_0000;
      if (is_addr(paddr_i, `IIFC_ADDR)) begin
        next_prdata[`IIFC_FIFO_STATUS_LSB +: 2] = {2{ctrl.fifo_enable}};
        next_prdata[3:0] = code;
      end else if (is_addr(paddr_i, `IIFC_STAT_ADDR)) begin
        next_prdata[5:0] = status;
      end else if (is_addr(paddr_i, `IIFC_MASK_ADDR)) begin
        next_prdata[5:0] = mask;
      end
    end
  end

  // Flow control and DMA requests; mode 1 holds a request until the FIFO drains or fills
  always_comb begin
    rx_any = ctrl.fifo_enable ? !rx_empty : rx_data_ready_i;
    tx_idle = ctrl.fifo_enable ? tx_empty : thr_empty_i;
    next_rts_n = !rts_req_i;
    if (auto_flow_en_i && ctrl.fifo_enable && rx_at_trigger) begin
      next_rts_n = 1'b1;
    end
    next_rx_dma_act = rx_dma_act;
    if (rx_empty) begin
      next_rx_dma_act = 1'b0;
    end
    if (rx_at_trigger || char_timeout_i) begin
      next_rx_dma_act = 1'b1;
    end
    next_tx_dma_act = tx_dma_act;
    if (tx_full) begin
      next_tx_dma_act = 1'b0;
    end
    if (tx_at_threshold) begin
      next_tx_dma_act = 1'b1;
    end
    if (ctrl.dma_signal_style && ctrl.fifo_enable) begin
      next_dma_rx_req_n = !next_rx_dma_act;
      next_dma_tx_req_n = !next_tx_dma_act;
    end else begin
      next_dma_rx_req_n = !rx_any;
      next_dma_tx_req_n = !tx_idle;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= uart_iifc_pkg::PH_IDLE;
      ctrl <= `IIFC_CTRL_RST;
      tx_fifo_flush_o <= 1'b0;
      rx_fifo_flush_o <= 1'b0;
      src_q <= '0;
      status <= `IIFC_STAT_RST;
      mask <= `IIFC_MASK_RST;
      prdata_o <= 32'h0000_0000;
      rts_n_o <= 1'b1;
      rx_dma_act <= 1'b0;
      tx_dma_act <= 1'b0;
      dma_rx_req_n_o <= 1'b1;
      dma_tx_req_n_o <= 1'b1;
      uart_int_o <= 1'b0;
    end else begin
      phase <= next_phase;
      ctrl <= next_ctrl;
      tx_fifo_flush_o <= next_tx_flush;
      rx_fifo_flush_o <= next_rx_flush;
      src_q <= next_src_q;
      status <= next_status;
      mask <= next_mask;
      prdata_o <= next_prdata;
      rts_n_o <= next_rts_n;
      rx_dma_act <= next_rx_dma_act;
      tx_dma_act <= next_tx_dma_act;
      dma_rx_req_n_o <= next_dma_rx_req_n;
      dma_tx_req_n_o <= next_dma_tx_req_n;
      uart_int_o <= next_uart_int;
    end
  end
  assign fifo_enable_o = ctrl.fifo_enable;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_shared_addr;
    wr_iifc |=> fifo_enable_o == $past(pwdata_i[0]) && ctrl.dma_signal_style == $past(pwdata_i[3]);
  endproperty
  a_shared_addr: assert property (p_shared_addr) else $error("control write lost");

  property p_fifo_enabled_status;
    rd_setup && is_addr(paddr_i, `IIFC_ADDR)
      |=> prdata_o[7:6] == (fifo_enable_o ? 2'h3 : 2'h0);
  endproperty
  a_fifo_enabled_status: assert property (p_fifo_enabled_status) else $error("fifo enabled status wrong");

  property p_code;
    rd_setup && is_addr(paddr_i, `IIFC_ADDR) && !(|src) |=> prdata_o[3:0] == 4'h1;
  endproperty
  a_code: assert property (p_code) else $error("idle code not 0001");

  property p_rx_trig;
    fifo_enable_o && ctrl.rx_trigger_level == 2'h0 && rx_fifo_level_i != '0
      && rx_data_int_en_i && !src.line_status |-> code == uart_iifc_pkg::INT_RDA;
  endproperty
  a_rx_trig: assert property (p_rx_trig) else $error("no data interrupt at one char");

  property p_rts;
    auto_flow_en_i && fifo_enable_o && rx_at_trigger |=> rts_n_o;
  endproperty
  a_rts: assert property (p_rts) else $error("rts_n not deasserted at trigger");

  property p_dma_rx;
    ctrl.dma_signal_style && fifo_enable_o && rx_at_trigger |=> !dma_rx_req_n_o;
  endproperty
  a_dma_rx: assert property (p_dma_rx) else $error("rx dma request missing");

  property p_tx_hold_empty;
    prog_tx_empty_mode_i && fifo_enable_o && tx_empty_int_en_i && tx_at_threshold
      |-> src.tx_empty;
  endproperty
  a_tx_hold_empty: assert property (p_tx_hold_empty) else $error("thr empty not raised");

  property p_dma_tx;
    ctrl.dma_signal_style && fifo_enable_o && tx_at_threshold |=> !dma_tx_req_n_o;
  endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("tx dma request missing");

  property p_dma_m0;
    !ctrl.dma_signal_style && fifo_enable_o && !rx_empty |=> !dma_rx_req_n_o;
  endproperty
  a_dma_m0: assert property (p_dma_m0) else $error("mode 0 rx request missing");

  property p_tx_flush;
    wr_iifc && pwdata_i[2] |=> tx_fifo_flush_o ##1 (!tx_fifo_flush_o || $past(wr_iifc));
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush not one pulse");

  property p_rx_flush;
    wr_iifc && pwdata_i[1] |=> rx_fifo_flush_o ##1 (!rx_fifo_flush_o || $past(wr_iifc));
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush not one pulse");

  property p_prio;
    src.line_status |-> code == uart_iifc_pkg::INT_RLS;
  endproperty
  a_prio: assert property (p_prio) else $error("line status not top priority");

  property p_reserved;
    rd_setup && is_addr(paddr_i, `IIFC_ADDR) |=> prdata_o[31:8] == 24'h000000
      && prdata_o[5:4] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  c_flush: cover property (wr_iifc && pwdata_i[2] && pwdata_i[1]);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_dma1: cover property (ctrl.dma_signal_style && !dma_rx_req_n_o);
endmodule : uart_int_ident_fifo_ctrl
`default_nettype wire

// ### tb/far_side_model.sv
// Far side of the block: a remote sender paced by rts_n and a DMA reader of the rx FIFO.
// Assumes the bench loads FIFO levels directly through load_i between scenarios.
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter int LW = 5,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic rts_n_i,
  input wire logic dma_rx_req_n_i,
  input wire logic rx_fifo_flush_i,
  input wire logic tx_fifo_flush_i,
  input wire logic send_en_i,
  input wire logic dma_en_i,
  input wire logic load_i,
  input wire logic [LW-1:0] rx_load_i,
  input wire logic [LW-1:0] tx_load_i,
  output logic [LW-1:0] rx_level_o,
  output logic [LW-1:0] tx_level_o
);
  logic [1:0] pace;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pace <= 2'h0;
      rx_level_o <= '0;
      tx_level_o <= '0;
    end else begin
      pace <= pace + 2'h1;
      if (load_i) begin
        rx_level_o <= rx_load_i;
        tx_level_o <= tx_load_i;
      end else begin
        if (rx_fifo_flush_i) begin
          rx_level_o <= '0;
        // A real sender is slow: one character every four cycles, only while rts_n is low
        end else if (send_en_i && pace == 2'h3 && !rts_n_i && rx_level_o < DEPTH) begin
          rx_level_o <= rx_level_o + 1'b1;
        end else if (dma_en_i && !dma_rx_req_n_i && rx_level_o != 0) begin
          rx_level_o <= rx_level_o - 1'b1;
        end
        if (tx_fifo_flush_i) begin
          tx_level_o <= '0;
        end
      end
    end
  end
endmodule : far_side_model
`default_nettype wire

// ### tb/uart_int_ident_fifo_ctrl_bench.sv
// Self-checking bench for the interrupt ident / FIFO control block.
// Assumes far_side_model supplies FIFO levels; the APB master lives here.
`timescale 1ns/1ps
`default_nettype none
`include "uart_iifc_map.svh"
module uart_int_ident_fifo_ctrl_bench;
  localparam int LW = 5;
  logic clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, q;
  logic [LW-1:0] rx_fifo_level_i, tx_fifo_level_i, rx_ld, tx_ld;
  logic rx_data_ready_i, thr_empty_i, line_status_err_i, char_timeout_i;
  logic modem_status_chg_i, busy_detect_i, line_status_int_en_i, rx_data_int_en_i;
  logic tx_empty_int_en_i, modem_status_int_en_i, prog_tx_empty_mode_i, auto_flow_en_i, rts_req_i;
  logic fifo_enable_o, tx_fifo_flush_o, rx_fifo_flush_o, rts_n_o, dma_tx_req_n_o;
  logic dma_rx_req_n_o, uart_int_o, irq_o, serr, send_en, dma_en, ld;
  int failures = 0, compares = 0, txf = 0, rxf = 0, n, r, t;
  int trig[4] = '{1, 4, 8, 14};
  int thr[4] = '{0, 2, 4, 8};
  int rxs[5] = '{0, 3, 4, 1, 0};
  int txs[5] = '{16, 16, 2, 5, 16};
  int rqs[5] = '{1, 1, 0, 0, 1};

  uart_int_ident_fifo_ctrl #(.DEPTH(16), .LW(LW)) u_uart_int_ident_fifo_ctrl (.*);
  far_side_model #(.LW(LW), .DEPTH(16)) u_far_side_model (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .rts_n_i(rts_n_o), .dma_rx_req_n_i(dma_rx_req_n_o),
    .rx_fifo_flush_i(rx_fifo_flush_o), .tx_fifo_flush_i(tx_fifo_flush_o),
    .send_en_i(send_en), .dma_en_i(dma_en), .load_i(ld), .rx_load_i(rx_ld),
    .tx_load_i(tx_ld), .rx_level_o(rx_fifo_level_i), .tx_level_o(tx_fifo_level_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Pulses counted per edge, so a stuck flush shows as a count above one
  always @(posedge clk_sys_i) begin
    if (tx_fifo_flush_o === 1'b1) txf++;
    if (rx_fifo_flush_o === 1'b1) rxf++;
  end

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // No wait-state count is assumed: the watchdog ends a hung access
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  task automatic lvl(input int rl, input int tl);
    ld <= 1'b1;
    rx_ld <= LW'(rl);
    tx_ld <= LW'(tl);
    @(posedge clk_sys_i);
    ld <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : lvl

  function automatic logic [3:0] exp_code(input int trg_sel, input int thr_sel, input bit fen);
    bit rda, th;
    rda = fen ? (rx_fifo_level_i >= trig[trg_sel]) : rx_data_ready_i;
    // FIFO mode without the programmable threshold flags only a fully drained FIFO
    th = !fen ? thr_empty_i : (prog_tx_empty_mode_i ? (tx_fifo_level_i <= thr[thr_sel])
      : (tx_fifo_level_i == 0));
    if (line_status_err_i && line_status_int_en_i) return 4'h6;
    if (rda && rx_data_int_en_i) return 4'h4;
    if (char_timeout_i && fen && rx_data_int_en_i) return 4'hC;
    if (th && tx_empty_int_en_i) return 4'h2;
    if (modem_status_chg_i && modem_status_int_en_i) return 4'h0;
    if (busy_detect_i) return 4'h7;
    return 4'h1;
  endfunction : exp_code

  task automatic code(input int trg_sel, input int thr_sel, input logic fen);
    logic [3:0] e;
    e = exp_code(trg_sel, thr_sel, fen);
    apb(1'b0, `IIFC_ADDR, 32'h0);
    chk("ident", {24'h0, {2{fen}}, 2'b00, e}, q);
    chk("uart_int", 32'(e != 4'h1), 32'(uart_int_o));
  endtask : code

  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {rx_data_ready_i, thr_empty_i, line_status_err_i, char_timeout_i, modem_status_chg_i} = '0;
    {busy_detect_i, line_status_int_en_i, rx_data_int_en_i, tx_empty_int_en_i} = '0;
    {modem_status_int_en_i, prog_tx_empty_mode_i, auto_flow_en_i, rts_req_i} = '0;
    {send_en, dma_en, ld, rx_ld, tx_ld} = '0;
    reset_n_i = 1'b0;
    void'($urandom(32'h6B8E720F));
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    code(0, 0, 1'b0);
    chk("rts_n", 1, rts_n_o);
    apb(1'b0, `IIFC_STAT_ADDR, 32'h0);
    chk("status", 0, q);
    apb(1'b1, `IIFC_ADDR, 32'hFFFF_FF01);
    chk("fifo_enable", 1, fifo_enable_o);
    code(0, 0, 1'b1);
    lvl(5, 5);
    apb(1'b1, `IIFC_ADDR, 32'h07);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("tx_flush_pulses", 1, txf);
    chk("rx_flush_pulses", 1, rxf);
    chk("tx_level", 0, 32'(tx_fifo_level_i));
    chk("rx_level", 0, 32'(rx_fifo_level_i));
    @(posedge clk_sys_i);
    code(0, 0, 1'b1);
    for (int i = 0; i < 20; i++) begin
      r = $urandom_range(16);
      t = $urandom_range(1);
      {line_status_err_i, char_timeout_i, modem_status_chg_i, busy_detect_i} <= 4'($urandom);
      {line_status_int_en_i, rx_data_int_en_i} <= 2'($urandom);
      {tx_empty_int_en_i, modem_status_int_en_i} <= 2'($urandom);
      thr_empty_i <= (t == 0);
      rx_data_ready_i <= (r != 0);
      apb(1'b1, `IIFC_ADDR, 32'((i % 4) * 64 + 1));
      lvl(r, t);
      code(i % 4, 0, 1'b1);
    end
    {line_status_err_i, char_timeout_i, modem_status_chg_i, busy_detect_i} <= 4'h0;
    {line_status_int_en_i, tx_empty_int_en_i, modem_status_int_en_i} <= 3'h0;
    {rx_data_int_en_i, auto_flow_en_i, rts_req_i, thr_empty_i} <= 4'hE;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `IIFC_ADDR, 32'(k * 64 + 1));
      lvl(trig[k] - 1, 1);
      code(k, 0, 1'b1);
      chk("rts_n_below", 0, rts_n_o);
      lvl(trig[k], 1);
      code(k, 0, 1'b1);
      chk("rts_n_at", 1, rts_n_o);
    end
    {rx_data_int_en_i, tx_empty_int_en_i, prog_tx_empty_mode_i, auto_flow_en_i} <= 4'h6;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `IIFC_ADDR, 32'(k * 16 + 1));
      lvl(0, thr[k]);
      code(0, k, 1'b1);
      lvl(0, thr[k] + 1);
      code(0, k, 1'b1);
    end
    {tx_empty_int_en_i, prog_tx_empty_mode_i} <= 2'h0;
    // Mode 1, trigger four characters, threshold two
    apb(1'b1, `IIFC_ADDR, 32'h59);
    for (int k = 0; k < 5; k++) begin
      lvl(rxs[k], txs[k]);
      chk("dma_rx_req_n", rqs[k], dma_rx_req_n_o);
      chk("dma_tx_req_n", rqs[k], dma_tx_req_n_o);
    end
    apb(1'b1, `IIFC_ADDR, 32'h51);
    lvl(1, 0);
    chk("dma_rx_req_n_m0", 0, dma_rx_req_n_o);
    chk("dma_tx_req_n_m0", 0, dma_tx_req_n_o);
    lvl(0, 1);
    chk("dma_rx_req_n_m0", 1, dma_rx_req_n_o);
    chk("dma_tx_req_n_m0", 1, dma_tx_req_n_o);
    apb(1'b1, `IIFC_STAT_ADDR, 32'h3F);
    {line_status_int_en_i, modem_status_int_en_i} <= 2'h3;
    apb(1'b1, `IIFC_MASK_ADDR, 32'h20);
    {line_status_err_i, modem_status_chg_i} <= 2'h3;
    repeat (2) @(posedge clk_sys_i);
    apb(1'b0, `IIFC_STAT_ADDR, 32'h0);
    chk("status", 32'h22, q);
    chk("irq", 1, irq_o);
    apb(1'b1, `IIFC_STAT_ADDR, 32'h20);
    apb(1'b0, `IIFC_STAT_ADDR, 32'h0);
    chk("status", 32'h02, q);
    chk("irq_masked", 0, irq_o);
    apb(1'b0, `IIFC_MASK_ADDR, 32'h0);
    chk("mask", 32'h20, q);
    apb(1'b0, 32'h5000_1190, 32'h0);
    chk("unmapped_err", 1, serr);
    chk("unmapped_data", 0, q);
    {line_status_err_i, modem_status_chg_i} <= 2'h0;
    {auto_flow_en_i, rts_req_i, send_en} <= 3'h7;
    apb(1'b1, `IIFC_ADDR, 32'h43);
    n = 0;
    while (rts_n_o !== 1'b1 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 300) failures++;
    repeat (20) @(posedge clk_sys_i);
    chk("rx_level_paused", trig[1], 32'(rx_fifo_level_i));
    send_en <= 1'b0;
    apb(1'b1, `IIFC_ADDR, 32'h49);
    dma_en <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    chk("rx_level_drained", 0, 32'(rx_fifo_level_i));
    chk("dma_rx_req_n_done", 1, dma_rx_req_n_o);
    close_out();
  end

  initial begin
    #(50 * 20000);
    failures++;
    close_out();
  end
endmodule : uart_int_ident_fifo_ctrl_bench
`default_nettype wire
